// ==== design/mief_pkg.sv ====
// mief_pkg: register map, bit positions, reset values and interrupt-register layout
// of the interrupt enable and flag unit.
// assumes: used as mief_pkg::name, never imported.
package mief_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int NUM_SRC = 7;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [3:0] IRQ_ENABLE_OFS = 4'hE;
   localparam logic [3:0] IRQ_FLAG_OFS = 4'hF;
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] EVT_STAT_OFS = 4'h1;
   localparam logic [3:0] EVT_CLR_OFS = 4'h2;
   localparam logic [3:0] EVT_EN_OFS = 4'h3;

   // ------------------------------------------------------------
   // bit positions of the enable and flag registers
   // ------------------------------------------------------------
   localparam int TMR_ZERO_OVF_BIT = 0;
   localparam int PORTB_CHANGE_BIT = 1;
   localparam int EXT_PIN_IRQ_BIT = 2;
   localparam int TMR_ONE_UDF_BIT = 3;
   localparam int LOW_VOLT_IRQ_BIT = 4;
   localparam int TMR_TWO_UDF_BIT = 5;
   localparam int WATCHDOG_IRQ_BIT = 6;

   // ------------------------------------------------------------
   // control register fields
   // ------------------------------------------------------------
   localparam int CTRL_GLOBAL_EN_BIT = 0;
   localparam int CTRL_EDGE_SEL_BIT = 1;
   localparam int CTRL_PIN_SEL_BIT = 2;

   // ------------------------------------------------------------
   // event status layout (block-level interrupt)
   // ------------------------------------------------------------
   localparam int EVT_W = 2;
   localparam int EVT_REQ_RISE_BIT = 0;
   localparam int EVT_FLAG_SET_BIT = 1;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [6:0] IRQ_ENABLE_RST = 7'h00;
   localparam logic [6:0] IRQ_FLAG_RST = 7'h00;
   localparam logic GLOBAL_EN_RST = 1'b0;
   localparam logic EDGE_SEL_RST = 1'b0;
   localparam logic PIN_SEL_RST = 1'b0;
   localparam logic [1:0] EVT_RST = 2'h0;

endpackage : mief_pkg

// ==== design/mief_flag_if.sv ====
// mief_flag_if: carries the per-source flag bank controls between the top and the bank.
// assumes: one clock domain; the top drives set and clear, the bank drives flags.
`timescale 1ns/1ps
interface mief_flag_if #(parameter int N = 7);
   logic [N-1:0] set_pulse;
   logic [N-1:0] clr_mask;
   logic [N-1:0] flags;

   modport ctrl (output set_pulse, output clr_mask, input flags);
   modport bank (input set_pulse, input clr_mask, output flags);
endinterface : mief_flag_if

// ==== design/mief_flag_bank.sv ====
// mief_flag_bank: one sticky flag per source, set by hardware, cleared by firmware.
// assumes: set and clear arrive as one-cycle pulses on core_clk_i.
`timescale 1ns/1ps
module mief_flag_bank #(
   parameter int N = 7
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   mief_flag_if.bank fb
);
   logic [N-1:0] flag_ff;

   // ------------------------------------------------------------
   // sticky flags
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_flag
         // set beats clear so an event in the clearing cycle is kept
         always_ff @(posedge core_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               flag_ff[g] <= 1'b0;
            end else if (fb.set_pulse[g]) begin
               flag_ff[g] <= 1'b1;
            end else if (fb.clr_mask[g]) begin
               flag_ff[g] <= 1'b0;
            end
         end
      end
   endgenerate

   assign fb.flags = flag_ff;
endmodule : mief_flag_bank

// ==== design/mief_edge_sync.sv ====
// mief_edge_sync: two-flop synchroniser and edge detector for port-B pin 0.
// assumes: the pin is asynchronous to core_clk_i.
`timescale 1ns/1ps
module mief_edge_sync (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic pin_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic meta_ff;
   logic sync_ff;
   logic prev_ff;

   // ------------------------------------------------------------
   // synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         meta_ff <= pin_i;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign level_o = sync_ff;
   assign rise_o = sync_ff & ~prev_ff;
   assign fall_o = ~sync_ff & prev_ff;
endmodule : mief_edge_sync

// ==== design/mief_top.sv ====
// mief_top: interrupt enable and flag unit of a small 8-bit controller core.
// assumes: event inputs are one-cycle pulses from logic on core_clk_i; portb_pin_zero_i
// comes from a pin; register port with read data one cycle after the read strobe.
//
// Operation
// - enable register: one bit per source, bits 6..0, reset to zero.
// - flag register shares enable layout; each event sets its flag.
// - flags stay set; only a firmware write clears them.
// - flag read returns zero where the source enable is zero.
// - edge select one picks rising, zero falling edge on pin zero.
// - global enable gates all sources at core_irq_req_o, not the flag-set event of blk_irq_o; instructions set and clear it.
// - pin zero is external interrupt input only when pin select is one.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module mief_top #(
   parameter int N = mief_pkg::NUM_SRC
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic tmr_zero_ovf_i,
   input wire logic portb_change_i,
   input wire logic tmr_one_udf_i,
   input wire logic low_volt_i,
   input wire logic tmr_two_udf_i,
   input wire logic watchdog_timeout_i,
   input wire logic portb_pin_zero_i,
   input wire logic enable_irq_instr_i,
   input wire logic disable_irq_instr_i,
   output logic core_irq_req_o,
   output logic ext_pin_select_o,
   output logic blk_irq_o
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [N-1:0] irq_enable_ff;
   logic global_irq_enable_ff;
   logic ext_edge_select_ff;
   logic ext_pin_select_ff;
   logic [1:0] evt_stat_ff;
   logic [1:0] evt_en_ff;
   logic req_prev_ff;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic pin_rise;
   logic pin_fall;
   logic ext_evt;
   logic [N-1:0] evt_vec;
   logic [N-1:0] flag_wr_clr;
   logic [N-1:0] pending;
   logic req;
   logic wr_enable;
   logic wr_flag;
   logic wr_ctrl;

   mief_flag_if #(.N(N)) fb_if ();

   // ------------------------------------------------------------
   // submodules
   // ------------------------------------------------------------
   mief_edge_sync u_sync (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .pin_i(portb_pin_zero_i),
      .level_o(),
      .rise_o(pin_rise),
      .fall_o(pin_fall)
   );

   mief_flag_bank #(.N(N)) u_bank (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .fb(fb_if.bank)
   );

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   assign wr_enable = reg_wr_i && (reg_addr_i == mief_pkg::IRQ_ENABLE_OFS);
   assign wr_flag = reg_wr_i && (reg_addr_i == mief_pkg::IRQ_FLAG_OFS);
   assign wr_ctrl = reg_wr_i && (reg_addr_i == mief_pkg::CTRL_OFS);

   // ------------------------------------------------------------
   // events
   // ------------------------------------------------------------
   // pin ignored as gpio, edge chosen by select
   assign ext_evt = ext_pin_select_ff && (ext_edge_select_ff ? pin_rise : pin_fall);

   always_comb begin
      evt_vec = '0;
      evt_vec[mief_pkg::TMR_ZERO_OVF_BIT] = tmr_zero_ovf_i;
      evt_vec[mief_pkg::PORTB_CHANGE_BIT] = portb_change_i;
      evt_vec[mief_pkg::EXT_PIN_IRQ_BIT] = ext_evt;
      evt_vec[mief_pkg::TMR_ONE_UDF_BIT] = tmr_one_udf_i;
      evt_vec[mief_pkg::LOW_VOLT_IRQ_BIT] = low_volt_i;
      evt_vec[mief_pkg::TMR_TWO_UDF_BIT] = tmr_two_udf_i;
      evt_vec[mief_pkg::WATCHDOG_IRQ_BIT] = watchdog_timeout_i;
   end

   // a written zero clears, a written one leaves the flag alone
   assign flag_wr_clr = wr_flag ? ~reg_wdata_i[N-1:0] : '0;
   assign fb_if.set_pulse = evt_vec;
   assign fb_if.clr_mask = flag_wr_clr;

   // ------------------------------------------------------------
   // enable register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_enable_ff <= mief_pkg::IRQ_ENABLE_RST;
      end else if (wr_enable) begin
         irq_enable_ff <= reg_wdata_i[N-1:0];
      end
   end

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ext_edge_select_ff <= mief_pkg::EDGE_SEL_RST;
         ext_pin_select_ff <= mief_pkg::PIN_SEL_RST;
      end else if (wr_ctrl) begin
         ext_edge_select_ff <= reg_wdata_i[mief_pkg::CTRL_EDGE_SEL_BIT];
         ext_pin_select_ff <= reg_wdata_i[mief_pkg::CTRL_PIN_SEL_BIT];
      end
   end

   // instructions win over a register write in the same cycle
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         global_irq_enable_ff <= mief_pkg::GLOBAL_EN_RST;
      end else if (enable_irq_instr_i) begin
         global_irq_enable_ff <= 1'b1;
      end else if (disable_irq_instr_i) begin
         global_irq_enable_ff <= 1'b0;
      end else if (wr_ctrl) begin
         global_irq_enable_ff <= reg_wdata_i[mief_pkg::CTRL_GLOBAL_EN_BIT];
      end
   end

   // ------------------------------------------------------------
   // request to core
   // ------------------------------------------------------------
   assign pending = fb_if.flags & irq_enable_ff;
   assign req = global_irq_enable_ff && (|pending);
   assign core_irq_req_o = req;
   assign ext_pin_select_o = ext_pin_select_ff;

   // ------------------------------------------------------------
   // block events: request rise, any flag set
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         req_prev_ff <= 1'b0;
      end else begin
         req_prev_ff <= req;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         evt_stat_ff <= mief_pkg::EVT_RST;
      end else begin
         for (int i = 0; i < mief_pkg::EVT_W; i++) begin
            if ((i == mief_pkg::EVT_REQ_RISE_BIT && req && !req_prev_ff) ||
                (i == mief_pkg::EVT_FLAG_SET_BIT && (|evt_vec))) begin
               evt_stat_ff[i] <= 1'b1;
            end else if (reg_wr_i && reg_addr_i == mief_pkg::EVT_CLR_OFS && reg_wdata_i[i]) begin
               evt_stat_ff[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         evt_en_ff <= mief_pkg::EVT_RST;
      end else if (reg_wr_i && reg_addr_i == mief_pkg::EVT_EN_OFS) begin
         evt_en_ff <= reg_wdata_i[1:0];
      end
   end

   assign blk_irq_o = |(evt_stat_ff & evt_en_ff);

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always_comb begin
      nxt_rdata = 8'h00;
      unique case (reg_addr_i)
         mief_pkg::IRQ_ENABLE_OFS: nxt_rdata = {1'b0, irq_enable_ff};
         // masked view: a disabled source always reads zero
         mief_pkg::IRQ_FLAG_OFS: nxt_rdata = {1'b0, pending};
         mief_pkg::CTRL_OFS: nxt_rdata = {5'h00, ext_pin_select_ff, ext_edge_select_ff, global_irq_enable_ff};
         mief_pkg::EVT_STAT_OFS: nxt_rdata = {6'h00, evt_stat_ff};
         mief_pkg::EVT_EN_OFS: nxt_rdata = {6'h00, evt_en_ff};
         default: nxt_rdata = 8'h00;
      endcase
   end

   // data stands only in the cycle after the strobe
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd_i) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign reg_rdata_o = rdata_ff;
endmodule : mief_top

// ==== tb/mief_top_monitor.sv ====
// mief_top_monitor: port-level assertions for the interrupt enable and flag unit.
// assumes: bound to mief_top; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
module mief_top_monitor #(
   parameter int N = 7
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic tmr_zero_ovf_i,
   input wire logic portb_change_i,
   input wire logic tmr_one_udf_i,
   input wire logic low_volt_i,
   input wire logic tmr_two_udf_i,
   input wire logic watchdog_timeout_i,
   input wire logic portb_pin_zero_i,
   input wire logic enable_irq_instr_i,
   input wire logic disable_irq_instr_i,
   input wire logic core_irq_req_o,
   input wire logic ext_pin_select_o,
   input wire logic blk_irq_o
);
   logic [6:0] en_sh_ff;
   logic gl_ff;
   logic pin_d_ff;
   logic [7:0] cause_ff;
   wire logic ctrl_wr = reg_wr_i && reg_addr_i == mief_pkg::CTRL_OFS;
   wire logic any_cause = tmr_zero_ovf_i | portb_change_i | tmr_one_udf_i | low_volt_i | tmr_two_udf_i
      | watchdog_timeout_i | reg_wr_i | enable_irq_instr_i | (portb_pin_zero_i != pin_d_ff);

   // ------------------------------------------------------------
   // shadow state
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         en_sh_ff <= 7'h00;
      end else if (reg_wr_i && reg_addr_i == mief_pkg::IRQ_ENABLE_OFS) begin
         en_sh_ff <= reg_wdata_i[6:0];
      end
   end
   // instructions win over a control write in the same cycle
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gl_ff <= 1'b0;
      end else if (enable_irq_instr_i) begin
         gl_ff <= 1'b1;
      end else if (disable_irq_instr_i) begin
         gl_ff <= 1'b0;
      end else if (ctrl_wr) begin
         gl_ff <= reg_wdata_i[0];
      end
   end
   // pin path is slow (sync plus detect), so causes are remembered eight cycles
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_d_ff <= 1'b0;
         cause_ff <= 8'h00;
      end else begin
         pin_d_ff <= portb_pin_zero_i;
         cause_ff <= {cause_ff[6:0], any_cause};
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   a_enable_readback: assert property (
      reg_rd_i && reg_addr_i == mief_pkg::IRQ_ENABLE_OFS |=> reg_rdata_o == {1'b0, $past(en_sh_ff)})
      else $error("enable register read mismatch");
   a_flag_read_masked: assert property (
      reg_rd_i && reg_addr_i == mief_pkg::IRQ_FLAG_OFS |=> (reg_rdata_o & ~{1'b0, $past(en_sh_ff)}) == 8'h00)
      else $error("flag read shows a disabled source");
   a_req_stays_set: assert property (
      core_irq_req_o && !reg_wr_i && !disable_irq_instr_i |=> core_irq_req_o)
      else $error("request dropped without firmware action");
   a_disable_blocks_req: assert property (
      disable_irq_instr_i && !enable_irq_instr_i |=> !core_irq_req_o)
      else $error("request after disable instruction");
   a_req_is_gated: assert property (
      core_irq_req_o |-> gl_ff && en_sh_ff != 7'h00)
      else $error("request without global and source enable");
   a_req_rise_cause: assert property (
      $rose(core_irq_req_o) |-> cause_ff != 8'h00)
      else $error("request rose with no event or write");
   a_pin_sel_write: assert property (
      ctrl_wr |=> ext_pin_select_o == $past(reg_wdata_i[2]))
      else $error("pin select does not follow control write");
   a_pin_sel_hold: assert property (
      !ctrl_wr |=> $stable(ext_pin_select_o))
      else $error("pin select changed without write");

   c_req: cover property (core_irq_req_o);
   c_pin_sel: cover property ($rose(ext_pin_select_o));
   c_blk_irq: cover property (blk_irq_o);
endmodule : mief_top_monitor

bind mief_top mief_top_monitor #(.N(N)) u_mief_top_monitor (.core_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i,
   .reg_wr_i, .reg_rd_i, .reg_rdata_o, .tmr_zero_ovf_i, .portb_change_i, .tmr_one_udf_i, .low_volt_i,
   .tmr_two_udf_i, .watchdog_timeout_i, .portb_pin_zero_i, .enable_irq_instr_i, .disable_irq_instr_i,
   .core_irq_req_o, .ext_pin_select_o, .blk_irq_o);

// ==== tb/mief_src_model.sv ====
// mief_src_model: on-chip timer, watchdog, detector and pin sources of the unit.
// assumes: the bench commands events by a one-cycle fire mask on core_clk_i.
`timescale 1ns/1ps
module mief_src_model (
   input wire logic core_clk_i,
   input wire logic [5:0] fire_i,
   input wire logic pin_lvl_i,
   output logic [5:0] evt_o,
   output logic pin_o
);
   // sources are clocked logic, so every event is a one-cycle pulse
   always_ff @(posedge core_clk_i) begin
      evt_o <= fire_i;
   end
   assign pin_o = pin_lvl_i;
endmodule : mief_src_model

// ==== tb/tb.sv ====
// tb: register-level tests of the interrupt enable and flag unit.
// assumes: mief_top with its bound monitor; the source model drives the events.
`timescale 1ns/1ps
module tb;
   logic core_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [3:0] reg_addr_i = 4'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic enable_irq_instr_i = 1'b0;
   logic disable_irq_instr_i = 1'b0;
   logic [5:0] fire = 6'h00;
   logic pin_lvl = 1'b1;
   logic [7:0] reg_rdata_o;
   logic [5:0] evt;
   logic pin, core_irq_req_o, ext_pin_select_o, blk_irq_o;
   int errors = 0;
   int checks = 0;
   localparam logic [7:0] SRC_BIT [6] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20, 8'h40};

   always #20 core_clk_i = ~core_clk_i;

   mief_src_model u_mief_src_model (.core_clk_i, .fire_i(fire), .pin_lvl_i(pin_lvl), .evt_o(evt), .pin_o(pin));
   mief_top u_mief_top (.core_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .tmr_zero_ovf_i(evt[0]), .portb_change_i(evt[1]), .tmr_one_udf_i(evt[2]), .low_volt_i(evt[3]),
      .tmr_two_udf_i(evt[4]), .watchdog_timeout_i(evt[5]), .portb_pin_zero_i(pin), .enable_irq_instr_i,
      .disable_irq_instr_i, .core_irq_req_o, .ext_pin_select_o, .blk_irq_o);

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
      @(posedge core_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(reg_rdata_o, exp);
   endtask : rdc
   task automatic global_irq_enable(input logic on);
      @(posedge core_clk_i);
      enable_irq_instr_i <= on;
      disable_irq_instr_i <= !on;
      @(posedge core_clk_i);
      enable_irq_instr_i <= 1'b0;
      disable_irq_instr_i <= 1'b0;
      #1;
   endtask : global_irq_enable
   task automatic shoot(input logic [5:0] m);
      @(posedge core_clk_i);
      fire <= m;
      @(posedge core_clk_i);
      fire <= 6'h00;
      @(posedge core_clk_i);
      #1;
   endtask : shoot
   // six cycles covers the two-flop sync and the edge detect
   task automatic pin_to(input logic lvl);
      @(posedge core_clk_i);
      pin_lvl <= lvl;
      repeat (6) @(posedge core_clk_i);
   endtask : pin_to
   task automatic conclude;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      rdc(mief_pkg::IRQ_ENABLE_OFS, 8'h00);
      rdc(mief_pkg::IRQ_FLAG_OFS, 8'h00);
      rdc(mief_pkg::CTRL_OFS, 8'h00);
      chk({7'h00, ext_pin_select_o}, 8'h00);
      // firmware keeps the low-voltage enable clear; bit 7 must not stick
      wr(mief_pkg::IRQ_ENABLE_OFS, 8'hEF);
      rdc(mief_pkg::IRQ_ENABLE_OFS, 8'h6F);
      // prescaler setup is outside this unit, nothing to order here
      for (int i = 0; i < 6; i++) begin
         shoot(6'h01 << i);
         rdc(mief_pkg::IRQ_FLAG_OFS, SRC_BIT[i] & 8'h6F);
         chk({7'h00, core_irq_req_o}, 8'h00);
         global_irq_enable(1'b1);
         chk({7'h00, core_irq_req_o}, {7'h00, |(SRC_BIT[i] & 8'h6F)});
         repeat (4) @(posedge core_clk_i);
         rdc(mief_pkg::IRQ_FLAG_OFS, SRC_BIT[i] & 8'h6F);
         global_irq_enable(1'b0);
         chk({7'h00, core_irq_req_o}, 8'h00);
         wr(mief_pkg::IRQ_FLAG_OFS, ~SRC_BIT[i]);
         rdc(mief_pkg::IRQ_FLAG_OFS, 8'h00);
      end
      shoot(6'h01);
      wr(mief_pkg::IRQ_ENABLE_OFS, 8'h6E);
      rdc(mief_pkg::IRQ_FLAG_OFS, 8'h00);
      wr(mief_pkg::IRQ_ENABLE_OFS, 8'h6F);
      rdc(mief_pkg::IRQ_FLAG_OFS, 8'h01);
      wr(mief_pkg::IRQ_FLAG_OFS, 8'hFE);
      pin_to(1'b0);
      pin_to(1'b1);
      rdc(mief_pkg::IRQ_FLAG_OFS, 8'h00);
      wr(mief_pkg::CTRL_OFS, 8'h06);
      rdc(mief_pkg::CTRL_OFS, 8'h06);
      chk({7'h00, ext_pin_select_o}, 8'h01);
      pin_to(1'b0);
      rdc(mief_pkg::IRQ_FLAG_OFS, 8'h00);
      pin_to(1'b1);
      rdc(mief_pkg::IRQ_FLAG_OFS, 8'h04);
      wr(mief_pkg::IRQ_FLAG_OFS, 8'hFB);
      wr(mief_pkg::CTRL_OFS, 8'h04);
      pin_to(1'b0);
      rdc(mief_pkg::IRQ_FLAG_OFS, 8'h04);
      wr(mief_pkg::IRQ_FLAG_OFS, 8'hFB);
      pin_to(1'b1);
      rdc(mief_pkg::IRQ_FLAG_OFS, 8'h00);
      // block interrupt: stale status cleared first, so the raise below is caused by the event
      wr(mief_pkg::EVT_CLR_OFS, 8'h03);
      rdc(mief_pkg::EVT_STAT_OFS, 8'h00);
      wr(mief_pkg::EVT_EN_OFS, 8'h02);
      rdc(mief_pkg::EVT_EN_OFS, 8'h02);
      chk({7'h00, blk_irq_o}, 8'h00);
      shoot(6'h04);
      chk({7'h00, blk_irq_o}, 8'h01);
      rdc(mief_pkg::EVT_STAT_OFS, 8'h02);
      wr(mief_pkg::EVT_CLR_OFS, 8'h03);
      rdc(mief_pkg::EVT_STAT_OFS, 8'h00);
      chk({7'h00, blk_irq_o}, 8'h00);
      // global enable by register write; pending timer1 flag raises the request
      wr(mief_pkg::CTRL_OFS, 8'h01);
      rdc(mief_pkg::EVT_STAT_OFS, 8'h01);
      chk({7'h00, core_irq_req_o}, 8'h01);
      rdc(mief_pkg::CTRL_OFS, 8'h01);
      // second reset in mid-run: state back to reset values
      @(posedge core_clk_i);
      reset_n_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      rdc(mief_pkg::IRQ_ENABLE_OFS, 8'h00);
      rdc(mief_pkg::CTRL_OFS, 8'h00);
      chk({7'h00, core_irq_req_o}, 8'h00);
      chk({7'h00, ext_pin_select_o}, 8'h00);
      wr(mief_pkg::IRQ_ENABLE_OFS, 8'h6F);
      rdc(mief_pkg::IRQ_FLAG_OFS, 8'h00);
      rdc(4'h7, 8'h00);
      conclude();
   end
endmodule : tb
